// ---- clbp_defines.svh ----
/*
 holds the named constants of the cpu local bus port.
 assumes inclusion by bare name from the port design files.
*/
`ifndef CLBP_DEFINES_SVH
`define CLBP_DEFINES_SVH
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLBP_CLK_NS        50
`define CLBP_WARM_CYCLES   256
`define CLBP_WARM_W        9
// ---------------------------------------------------------------
// bus widths and reset values
// ---------------------------------------------------------------
`define CLBP_DATA_W        32
`define CLBP_LANES         4
`define CLBP_CFG_W         32
`define CLBP_ZERO_DATA     32'h0000_0000
`define CLBP_LANES_IDLE    4'hf
`endif

// ---- clbp_pkg.sv ----
/*
 types shared by the cpu local bus port.
 assumes clbp_defines.svh is available.
*/
`include "clbp_defines.svh"
package clbp_pkg;
   // ------------------------------------------------------------
   // ownership and transfer states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      CLBP_IDLE,     // processor owns the bus
      CLBP_REQ,      // waiting for grant
      CLBP_XFER,     // dma beat on the bus
      CLBP_REL       // handing the bus back
   } clbp_own_t;
endpackage : clbp_pkg

// ---- clbp_warm_reset.sv ----
/*
 holds the warm reset stretcher for the processor.
 assumes cold reset is mapped onto the async reset input.
*/
`timescale 1ns/1ps
`include "clbp_defines.svh"
module clbp_warm_reset (
   // clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // warm reset to processor
   output logic      warm_reset_n
);
   // ------------------------------------------------------------
   // counter
   // ------------------------------------------------------------
   logic [`CLBP_WARM_W-1:0] cnt_reg;   // cycles since release
   wire                     done = (cnt_reg == `CLBP_WARM_W'(`CLBP_WARM_CYCLES - 1));
   // count up then hold; warm reset low until done
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_reg      <= '0;
         warm_reset_n <= 1'b0;
      end else begin
         if (!done) cnt_reg <= cnt_reg + `CLBP_WARM_W'(1);
         warm_reset_n <= done;
      end
   end
   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   logic [`CLBP_WARM_W:0] seen;  // helper: edges since release
   always_ff @(posedge clk or posedge reset) begin
      if (reset) seen <= '0;
      else if (!seen[`CLBP_WARM_W]) seen <= seen + 1'b1;
   end
   chk_warm_hold_time: assert property (@(posedge clk) disable iff (reset)
      warm_reset_n |-> (seen >= (`CLBP_WARM_W+1)'(`CLBP_WARM_CYCLES)))
      else $error("warm reset released early");
endmodule : clbp_warm_reset

// ---- clbp_port.sv ----
/*
 holds the cpu local bus port: address latch, acknowledge, bus error,
 dma bus request and grant, transceiver direction, interrupt, resets.
 assumes synchronous inputs on clk, cold reset tied to reset.
*/
// Function
// - acknowledge each accepted processor data word
// - bus error output for cpu and dma
// - all logic on the master clock
// - capture config vector on the first clock after cold reset
// - warm reset held 256 cycles minimum
// - request bus when dma needs it
// - interrupt output from internal controller
// - direction driven low during dma reads
// - direction floats when processor owns bus
// - dma drives data on writes only, no address phase
// - latch address on address latch enable
`timescale 1ns/1ps
`include "clbp_defines.svh"
module clbp_port (
   // clock and reset (cold reset)
   input  wire logic                      clk,
   input  wire logic                      reset,
   // processor bus inputs
   input  wire logic [`CLBP_DATA_W-1:0]   ad_in,
   input  wire logic                      ale,
   input  wire logic                      cycle_n,
   input  wire logic                      write_n,
   input  wire logic [`CLBP_LANES-1:0]    lane_select_lines,
   input  wire logic                      last_n,
   input  wire logic                      grant_n,
   // processor bus outputs
   output logic [`CLBP_DATA_W-1:0]        ad_out,
   output logic                           ad_oe,
   output logic                           ack_n,
   output logic                           buserr_n,
   output logic                           busreq_n,
   output logic                           int_n,
   output logic                           buffer_direction_out,
   output logic                           buffer_direction_oe,
   output logic                           warm_reset_n,
   // internal side
   input  wire logic [`CLBP_CFG_W-1:0]    cfg_strap,
   output logic [`CLBP_CFG_W-1:0]         cfg_vector,
   output logic [`CLBP_DATA_W-1:0]        cpu_addr,
   output logic [`CLBP_DATA_W-1:0]        cpu_wdata,
   output logic [`CLBP_LANES-1:0]         cpu_lanes,
   output logic                           cpu_wvalid,
   input  wire logic                      slave_ready,
   input  wire logic                      slave_error,
   input  wire logic                      irq_req,
   input  wire logic                      dma_start,
   input  wire logic                      dma_read,
   input  wire logic [`CLBP_DATA_W-1:0]   dma_wdata,
   input  wire logic                      dma_error,
   output logic                           dma_done
);
   // ------------------------------------------------------------
   // state and captured values
   // ------------------------------------------------------------
   clbp_pkg::clbp_own_t own_reg, own_next;  // bus ownership
   logic                cfg_taken;          // strap caught once
   logic                dma_rd_reg;         // current dma direction
   // decoding of the processor beat
   wire cpu_beat  = !cycle_n && !ale && (own_reg == clbp_pkg::CLBP_IDLE);
   wire cpu_acc   = cpu_beat && slave_ready && ack_n;
   wire granted   = !grant_n;
   // ownership sequencing
   always_comb begin
      own_next = own_reg;
      case (own_reg)
         clbp_pkg::CLBP_IDLE: begin
            if (dma_start && cycle_n) own_next = clbp_pkg::CLBP_REQ;
         end
         clbp_pkg::CLBP_REQ: begin
            if (granted) own_next = clbp_pkg::CLBP_XFER;
         end
         clbp_pkg::CLBP_XFER: begin
            if (!granted || slave_ready) own_next = clbp_pkg::CLBP_REL;
         end
         default: begin
            own_next = clbp_pkg::CLBP_IDLE;
         end
      endcase
   end
   // ------------------------------------------------------------
   // ownership and request register
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         own_reg    <= clbp_pkg::CLBP_IDLE;
         busreq_n   <= 1'b1;
         dma_rd_reg <= 1'b0;
         dma_done   <= 1'b0;
      end else begin
         own_reg  <= own_next;
         busreq_n <= !(own_next == clbp_pkg::CLBP_REQ ||
                       own_next == clbp_pkg::CLBP_XFER);
         if (own_reg == clbp_pkg::CLBP_IDLE && dma_start) dma_rd_reg <= dma_read;
         dma_done <= (own_reg == clbp_pkg::CLBP_XFER) && (own_next == clbp_pkg::CLBP_REL);
      end
   end
   // ------------------------------------------------------------
   // dma data drive and direction pin
   // ------------------------------------------------------------
   wire in_dma = (own_next == clbp_pkg::CLBP_XFER) && granted;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ad_out              <= `CLBP_ZERO_DATA;
         ad_oe               <= 1'b0;
         buffer_direction_out <= 1'b1;
         buffer_direction_oe <= 1'b0;
      end else begin
         ad_out              <= dma_wdata;
         ad_oe               <= in_dma && !dma_rd_reg;
         buffer_direction_out <= !(in_dma && dma_rd_reg);
         buffer_direction_oe <= in_dma;
      end
   end
   // ------------------------------------------------------------
   // processor address, data, acknowledge
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cpu_addr   <= `CLBP_ZERO_DATA;
         cpu_wdata  <= `CLBP_ZERO_DATA;
         cpu_lanes  <= `CLBP_LANES_IDLE;
         cpu_wvalid <= 1'b0;
         ack_n      <= 1'b1;
      end else begin
         if (ale) cpu_addr <= ad_in;
         cpu_wvalid <= cpu_acc && !write_n;
         if (cpu_acc) begin
            cpu_wdata <= ad_in;
            cpu_lanes <= lane_select_lines;
         end
         ack_n <= !cpu_acc;
      end
   end
   // one cycle acknowledge per word; last only ends the burst upstream
   // ------------------------------------------------------------
   // bus error, interrupt, config capture
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         buserr_n   <= 1'b1;
         int_n      <= 1'b1;
         cfg_taken  <= 1'b0;
         cfg_vector <= '0;
      end else begin
         buserr_n <= !((cpu_beat && slave_error) ||
                       (own_reg == clbp_pkg::CLBP_XFER && dma_error));
         int_n    <= !irq_req;
         if (!cfg_taken) begin
            cfg_vector <= cfg_strap;
            cfg_taken  <= 1'b1;
         end
      end
   end
   // ------------------------------------------------------------
   // warm reset stretcher
   // ------------------------------------------------------------
   clbp_warm_reset u_warm (
      .clk          (clk),
      .reset        (reset),
      .warm_reset_n (warm_reset_n)
   );
   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_req;  !busreq_n; endsequence
   sequence s_drv;  ad_oe;     endsequence
   chk_ack_follows_beat: assert property (@(posedge clk) disable iff (reset)
      cpu_acc |=> !ack_n) else $error("ack missing");
   chk_ack_one_cycle: assert property (@(posedge clk) disable iff (reset)
      !ack_n |=> ack_n) else $error("ack longer than one cycle");
   chk_drive_needs_grant: assert property (@(posedge clk) disable iff (reset)
      s_drv |-> ($past(granted) and s_req)) else $error("driving without grant");
   chk_dir_float_cpu: assert property (@(posedge clk) disable iff (reset)
      $past(own_reg == clbp_pkg::CLBP_IDLE && own_next == clbp_pkg::CLBP_IDLE)
      |-> !buffer_direction_oe) else $error("direction driven under cpu");
   chk_dir_dma_read: assert property (@(posedge clk) disable iff (reset)
      !buffer_direction_out |-> buffer_direction_oe) else $error("direction bad");
   chk_req_on_start: assert property (@(posedge clk) disable iff (reset)
      (own_reg == clbp_pkg::CLBP_IDLE && dma_start && cycle_n) |=> s_req)
      else $error("no bus request");
   chk_req_release: assert property (@(posedge clk) disable iff (reset)
      dma_done |-> busreq_n) else $error("request kept after dma");
   chk_addr_latch: assert property (@(posedge clk) disable iff (reset)
      ale |=> cpu_addr == $past(ad_in)) else $error("address not latched");
   chk_int_follow: assert property (@(posedge clk) disable iff (reset)
      irq_req |=> !int_n) else $error("interrupt not driven");
   chk_buserr_cpu: assert property (@(posedge clk) disable iff (reset)
      (cpu_beat && slave_error) |=> !buserr_n) else $error("bus error missed");
endmodule : clbp_port

// ---- clbp_cpu_model.sv ----
/*
 processor side model: releases the local bus on a request.
 assumes the bench makes clk and drives the rest of the processor bus.
*/
`timescale 1ns/1ps
module clbp_cpu_model (
   // clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // arbitration
   input  wire logic busreq_n,
   input  wire integer grant_lat,
   output logic      grant_n
);
   int wait_cnt; // cycles already waited since the request

   // ---------------------------------------------
   // bus release
   // ---------------------------------------------
   // falling edge, like every processor output; grant_lat gives slow answers
   always @(negedge clk or posedge reset) begin
      if (reset) begin
         grant_n  <= 1'b1;
         wait_cnt <= 0;
      end else if (busreq_n) begin
         grant_n  <= 1'b1;
         wait_cnt <= 0;
      end else if (wait_cnt >= grant_lat) begin
         grant_n <= 1'b0;
      end else begin
         wait_cnt <= wait_cnt + 1;
      end
   end
endmodule : clbp_cpu_model

// ---- tb_top.sv ----
/*
 self-checking bench for the cpu local bus port.
 assumes the processor model is compiled before this file.
*/
`timescale 1ns/1ps
`include "clbp_defines.svh"
module tb_top;
   // ---------------------------------------------
   // signals
   // ---------------------------------------------
   logic              clk = 1'b0, reset = 1'b1, ale = 1'b0, cycle_n = 1'b1, write_n = 1'b1;
   logic              last_n = 1'b1, slave_ready = 1'b0, slave_error = 1'b0, irq_req = 1'b0;
   logic              dma_start = 1'b0, dma_read = 1'b0, dma_error = 1'b0, grant_n;
   logic [3:0]        lane_select_lines = 4'hf, cpu_lanes;
   logic [31:0]       ad_in = '0, dma_wdata = '0, cfg_strap = '0;
   logic [31:0]       ad_out, cfg_vector, cpu_addr, cpu_wdata;
   logic              ad_oe, ack_n, buserr_n, busreq_n, int_n, warm_reset_n;
   logic              buffer_direction_out, buffer_direction_oe, cpu_wvalid, dma_done;
   int                fails = 0, check_count = 0, grant_lat = 0, err_hits = 0, n;
   logic [67:0]       notes[$]; // expected address, data, lanes per write

   always #(`CLBP_CLK_NS/2) clk = ~clk; // one master clock

   clbp_port clbp_port_i (.clk, .reset, .ad_in, .ale, .cycle_n, .write_n, .lane_select_lines,
      .last_n, .grant_n, .ad_out, .ad_oe, .ack_n, .buserr_n, .busreq_n, .int_n,
      .buffer_direction_out, .buffer_direction_oe, .warm_reset_n, .cfg_strap, .cfg_vector,
      .cpu_addr, .cpu_wdata, .cpu_lanes, .cpu_wvalid, .slave_ready, .slave_error, .irq_req,
      .dma_start, .dma_read, .dma_wdata, .dma_error, .dma_done);
   clbp_cpu_model clbp_cpu_model_i (.clk, .reset, .busreq_n, .grant_lat, .grant_n);

   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   function automatic bit miss(input bit bad);
      check_count++;
      if (bad) fails++;
      return bad;
   endfunction : miss

   task end_sim;
      if (fails == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim

   // one processor word: address phase then data phase until acknowledged
   task automatic cpu_word(input logic [31:0] a, d, input logic [3:0] l, input bit wr);
      if (wr) notes.push_back({a, d, l});
      ale = 1'b1;
      ad_in = a;
      cycle_n = 1'b0;
      write_n = !wr;
      @(negedge clk);
      ale = 1'b0;
      ad_in = d;
      lane_select_lines = l;
      last_n = 1'b0;
      slave_ready = 1'b1;
      n = 0;
      while (ack_n !== 1'b0 && n < 8) begin
         @(negedge clk);
         n++;
      end
      if (miss(ack_n !== 1'b0 || cpu_addr !== a)) $display("Error at %0t: no ack", $time);
      cycle_n = 1'b1;
      slave_ready = 1'b0;
      last_n = 1'b1;
      ad_in = ~d; // released bus does not keep the data
      @(negedge clk);
      if (miss(ack_n !== 1'b1)) $display("Error at %0t: ack too long", $time);
   endtask : cpu_word

   // one dma beat: request, wait for grant, end with slave_ready
   task automatic dma_run(input bit rd, input int lat, input bit fail);
      grant_lat = lat;
      dma_read = rd;
      dma_wdata = $urandom;
      dma_error = fail;
      ad_in = ~ad_in;
      dma_start = 1'b1;
      @(negedge clk);
      dma_start = 1'b0;
      @(negedge clk);
      if (miss(busreq_n !== 1'b0)) $display("Error at %0t: no request", $time);
      n = 0;
      while (buffer_direction_oe !== 1'b1 && n < 20) begin
         if (miss(ad_oe !== 1'b0)) $display("Error at %0t: drove before grant", $time);
         @(negedge clk);
         n++;
      end
      if (miss(grant_n !== 1'b0 || buffer_direction_out !== !rd))
         $display("Error at %0t: dir", $time);
      if (miss(ad_oe !== !rd || (!rd && ad_out !== dma_wdata)))
         $display("Error at %0t: data", $time);
      slave_ready = 1'b1;
      @(negedge clk);
      slave_ready = 1'b0;
      dma_error = 1'b0;
      n = 0;
      while (dma_done !== 1'b1 && n < 4) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      if (miss(dma_done !== 1'b0 || busreq_n !== 1'b1 ||
               buffer_direction_oe !== 1'b0 || n > 2))
         $display("Error at %0t: bus not handed back", $time);
   endtask : dma_run

   // ---------------------------------------------
   // result watchers
   // ---------------------------------------------
   always @(negedge clk) begin
      if (buserr_n === 1'b0) err_hits++;
      if (cpu_wvalid === 1'b1) begin
         if (miss(notes.size() == 0)) $display("Error at %0t: write on a read", $time);
         else if (miss({cpu_addr, cpu_wdata, cpu_lanes} !== notes.pop_front()))
            $display("Error at %0t: write word wrong", $time);
      end
   end

   initial begin
      #(3000 * `CLBP_CLK_NS);
      $display("Error at %0t: run timed out", $time);
      fails++;
      end_sim();
   end

   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      void'($urandom(97));
      cfg_strap = $urandom;
      repeat (5) @(negedge clk);
      if (miss(ack_n !== 1'b1 || buserr_n !== 1'b1 || busreq_n !== 1'b1 ||
               ad_oe !== 1'b0 || buffer_direction_oe !== 1'b0 || warm_reset_n !== 1'b0))
         $display("Error at %0t: reset values", $time);
      reset = 1'b0;
      n = 0;
      while (warm_reset_n !== 1'b1 && n < 300) begin
         @(negedge clk);
         n++;
      end
      if (miss(n < 256 || n > 257)) $display("Error at %0t: warm reset %0d", $time, n);
      if (miss(cfg_vector !== cfg_strap)) $display("Error at %0t: config", $time);
      for (int i = 0; i < 8; i++) cpu_word($urandom, $urandom, ~(4'h1 << i[1:0]), i != 5);
      if (miss(err_hits != 0 || notes.size() != 0)) $display("Error at %0t: cpu words", $time);
      slave_error = 1'b1;
      cpu_word($urandom, $urandom, 4'h0, 1'b0);
      slave_error = 1'b0;
      repeat (3) @(negedge clk);
      if (miss(err_hits == 0)) $display("Error at %0t: no bus error", $time);
      for (int i = 0; i < 4; i++) dma_run(i[0], i * 3, 1'b0);
      err_hits = 0;
      dma_run(1'b1, 1, 1'b1);
      if (miss(err_hits == 0)) $display("Error at %0t: no dma bus error", $time);
      for (int i = 0; i < 6; i++) begin
         irq_req = $urandom;
         @(negedge clk);
         if (miss(int_n !== !irq_req)) $display("Error at %0t: interrupt", $time);
      end
      end_sim();
   end
endmodule : tb_top
